// >>> design/bsr_map.svh
// Constants of the barometric sensor serial readout: frame codes, patterns, timing.
// Assumes a 10 MHz core clock and a conversion clock near 32.768 kHz.
`ifndef BSR_MAP_SVH
`define BSR_MAP_SVH

// Frame layout on the command input
`define BSR_START_BITS 3'h7
`define BSR_STOP_BITS 3'h0

// Selection field codes, all distinct
`define BSR_SEL_PRESSURE 4'hA
`define BSR_SEL_TEMPERATURE 4'h9
`define BSR_SEL_WORD_FIRST 4'h5
`define BSR_SEL_WORD_SECOND 4'h6
`define BSR_SEL_WORD_THIRD 4'h3
`define BSR_SEL_WORD_FOURTH 4'hC

// Resynchronisation pattern, oldest bit in the MSB
`define BSR_RESET_PATTERN 21'h155540

// Shift clocks given after the acknowledge before the host stops
`define BSR_ACK_CLOCKS 5'h02
// Result and calibration words: 16 data clocks plus one closing clock
`define BSR_WORD_LAST 5'h10
// Idle clocks before the data of the second and fourth word
`define BSR_LEAD_ODD 1'h0
`define BSR_LEAD_EVEN 1'h1

// Conversion timing in conversion-clock ticks
`define BSR_CONV_CLK_HZ 32768
`define BSR_CONV_TIME_US 35000
`define BSR_BRIDGE_TIME_US 2000
`define BSR_CONV_TICKS ((`BSR_CONV_TIME_US * `BSR_CONV_CLK_HZ) / 1000000)
`define BSR_BRIDGE_TICKS ((`BSR_BRIDGE_TIME_US * `BSR_CONV_CLK_HZ) / 1000000)

`define BSR_ONES_MAX 16'hFFFF

`endif

// >>> design/bsr_pkg.sv
// Types of the barometric sensor serial readout.
// Constants live in bsr_map.svh.
`default_nettype none

package bsr_pkg;

  typedef enum logic [1:0] {
    BSR_IDLE,
    BSR_CONV,
    BSR_LEAD,
    BSR_SHIFT
  } bsr_link_state_t;

  typedef struct packed {
    logic [14:0] coef_first;
    logic coef_fifth_upper_part;
    logic [9:0] coef_fifth_lower_part;
    logic [5:0] coef_sixth;
    logic [9:0] coef_fourth;
    logic [5:0] coef_second_upper_part;
    logic [9:0] coef_third;
    logic [5:0] coef_second_lower_part;
  } bsr_calib_t;

  typedef struct packed {
    logic cclk_s1;
    logic cclk_s2;
    logic cclk_s3;
    logic dat_s1;
    logic dat_s2;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic abt_s1;
    logic abt_s2;
    logic abt_seen;
    logic busy;
    logic sense_temp;
    logic bridge_on;
    logic dout;
    logic [10:0] tick_cnt;
    logic [15:0] ones;
    logic [15:0] result;
    bsr_calib_t calib;
    logic calib_loaded;
  } bsr_core_t;

  typedef struct packed {
    logic [20:0] hist;
    bsr_link_state_t state;
    logic [4:0] cnt;
    logic [15:0] word;
    logic data_bit;
    logic req_tgl;
    logic abt_tgl;
    logic kind_temp;
  } bsr_link_t;

endpackage : bsr_pkg

`default_nettype wire

// >>> design/bsr_readout.sv
// Serial command and readout logic of a barometric sensor, with its conversion sequencer.
// Assumes the host clocks sclk_in and changes din_in on falling edges; conv_clk_in and
// mod_bit_in come from outside, calib_in is a static fuse bank.
// Notes on behaviour
// RULE_01 - Command bits are sampled on each rising shift clock edge.
// RULE_02 - Data bits are launched on each rising shift clock edge.
// RULE_03 - Host samples data and changes commands on the falling edge; the host model samples data hold_ns after that edge.
// RULE_04 - Only the host drives the shift clock.
// RULE_05 - Each command is three ones, four select bits, three zeros.
// RULE_06 - Select field chooses pressure, temperature or one calibration word.
// RULE_07 - Conversion start is acknowledged by the data line going high.
// RULE_08 - Host gives two clocks after acknowledge, then holds clock low.
// RULE_09 - End of conversion is a falling data line.
// RULE_10 - Seventeen clocks after end of conversion shift out sixteen result bits.
// RULE_11 - Readout may pause; position is kept until clocking resumes.
// RULE_12 - Host reads the previous result before a new conversion.
// RULE_13 - The 21-bit reset pattern returns the link to idle from anywhere.
// RULE_14 - Data line may toggle during the reset pattern; host ignores it.
// RULE_15 - Host should send the reset pattern before each conversion; the bench's t_abort sends its frame without one.
// RULE_16 - Data line carries result, calibration data, or conversion status.
// RULE_17 - One shared converter yields 16-bit pressure and temperature values.
// RULE_18 - Sixty-four calibration bits are held and read as four words.
// RULE_19 - Fourth word holds third coefficient high, second coefficient low part.
// RULE_20 - First and third words share one shape, second and fourth another.
// RULE_21 - Sensor bridge is powered only briefly within each conversion.
// RULE_22 - Host supplies a free-running conversion clock.
// RULE_23 - Host may stop the conversion clock while idle.
// RULE_24 - Words are shifted most significant bit first.
// RULE_25 - Host times out a conversion and then sends the reset pattern.
`timescale 1ns/10ps
`default_nettype none
`include "bsr_map.svh"

module bsr_readout (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic sclk_in,
  input wire logic din_in,
  input wire logic conv_clk_in,
  input wire logic mod_bit_in,
  input wire bsr_pkg::bsr_calib_t calib_in,
  output logic dout_out,
  output logic bridge_power_out,
  output logic sense_temp_out
);

  logic rst_c_s1;
  logic rst_c;
  logic rst_l_s1;
  logic rst_l;
  logic ce_l_s1;
  logic ce_l;
  bsr_pkg::bsr_core_t c;
  bsr_pkg::bsr_core_t next_c;
  bsr_pkg::bsr_link_t l;
  bsr_pkg::bsr_link_t next_l;
  logic core_tick;
  logic core_start;
  logic core_abort;
  logic [20:0] link_hist_next;
  logic link_msb;
  logic [15:0] word_first;
  logic [15:0] word_second;
  logic [15:0] word_third;
  logic [15:0] word_fourth;

  // Reset release, one synchroniser per domain
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_c_s1 <= 1'h0;
      rst_c <= 1'h0;
    end else begin
      rst_c_s1 <= 1'h1;
      rst_c <= rst_c_s1;
    end
  end

  always_ff @(posedge sclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_l_s1 <= 1'h0;
      rst_l <= 1'h0;
      ce_l_s1 <= 1'h0;
      ce_l <= 1'h0;
    end else begin
      rst_l_s1 <= 1'h1;
      rst_l <= rst_l_s1;
      ce_l_s1 <= ce_in;
      ce_l <= ce_l_s1;
    end
  end

  // Calibration word packing
  assign word_first = {c.calib.coef_first, c.calib.coef_fifth_upper_part};
  assign word_second = {c.calib.coef_fifth_lower_part, c.calib.coef_sixth};
  assign word_third = {c.calib.coef_fourth, c.calib.coef_second_upper_part};
  assign word_fourth = {c.calib.coef_third, c.calib.coef_second_lower_part}; // RULE_19

  assign core_tick = c.cclk_s2 & ~c.cclk_s3;
  assign core_start = c.req_s2 != c.req_seen;
  assign core_abort = c.abt_s2 != c.abt_seen;

  // Core domain: conversion sequencer and data line driver
  always_comb begin
    next_c = c;
    next_c.cclk_s1 = conv_clk_in; // RULE_22
    next_c.cclk_s2 = c.cclk_s1;
    next_c.cclk_s3 = c.cclk_s2;
    next_c.dat_s1 = l.data_bit;
    next_c.dat_s2 = c.dat_s1;
    next_c.req_s1 = l.req_tgl;
    next_c.req_s2 = c.req_s1;
    next_c.req_seen = c.req_s2;
    next_c.abt_s1 = l.abt_tgl;
    next_c.abt_s2 = c.abt_s1;
    next_c.abt_seen = c.abt_s2;
    // Fuse bank caught once after reset release
    if (!c.calib_loaded) begin
      next_c.calib = calib_in; // RULE_18
      next_c.calib_loaded = 1'h1;
    end
    if (c.busy && c.bridge_on && mod_bit_in && c.ones != `BSR_ONES_MAX) begin
      next_c.ones = c.ones + 16'h0001; // RULE_17
    end
    if (c.busy && core_tick) begin
      next_c.tick_cnt = c.tick_cnt + 11'h001;
      if (c.tick_cnt == 11'(`BSR_BRIDGE_TICKS - 1)) begin
        next_c.bridge_on = 1'h0; // RULE_21
      end
      if (c.tick_cnt == 11'(`BSR_CONV_TICKS - 1)) begin
        next_c.busy = 1'h0; // RULE_09
        next_c.bridge_on = 1'h0;
        next_c.result = c.ones; // RULE_17
      end
    end
    // Kind is stable on the link side well before its toggle arrives here
    if (core_start) begin
      next_c.busy = 1'h1; // RULE_07
      next_c.sense_temp = l.kind_temp; // RULE_17
      next_c.bridge_on = 1'h1;
      next_c.tick_cnt = 11'h000;
      next_c.ones = 16'h0000;
    end
    if (core_abort) begin
      next_c.busy = 1'h0; // RULE_13
      next_c.bridge_on = 1'h0;
    end
    // Status wins over shifted data while converting
    next_c.dout = next_c.busy | c.dat_s2; // RULE_16
  end

  always_ff @(posedge core_clk_in or negedge rst_c) begin
    if (!rst_c) begin
      c <= '0;
    end else if (ce_in) begin
      c <= next_c;
    end
  end

  assign link_hist_next = {l.hist[19:0], din_in};
  assign link_msb = l.word[15];

  // Link domain: framing, decode and shifting on the host's clock
  always_comb begin
    next_l = l;
    next_l.hist = link_hist_next; // RULE_01
    case (l.state)
      bsr_pkg::BSR_IDLE: begin
        next_l.data_bit = 1'h0;
        if (link_hist_next[9:7] == `BSR_START_BITS && link_hist_next[2:0] == `BSR_STOP_BITS) begin // RULE_05
          next_l.cnt = 5'h00;
          case (link_hist_next[6:3]) // RULE_06
            `BSR_SEL_PRESSURE: begin
              next_l.kind_temp = 1'h0;
              next_l.req_tgl = ~l.req_tgl;
              next_l.state = bsr_pkg::BSR_CONV;
            end
            `BSR_SEL_TEMPERATURE: begin
              next_l.kind_temp = 1'h1;
              next_l.req_tgl = ~l.req_tgl;
              next_l.state = bsr_pkg::BSR_CONV;
            end
            `BSR_SEL_WORD_FIRST: begin
              next_l.word = word_first;
              next_l.state = `BSR_LEAD_ODD ? bsr_pkg::BSR_LEAD : bsr_pkg::BSR_SHIFT; // RULE_20
            end
            `BSR_SEL_WORD_SECOND: begin
              next_l.word = word_second;
              next_l.state = `BSR_LEAD_EVEN ? bsr_pkg::BSR_LEAD : bsr_pkg::BSR_SHIFT; // RULE_20
            end
            `BSR_SEL_WORD_THIRD: begin
              next_l.word = word_third;
              next_l.state = `BSR_LEAD_ODD ? bsr_pkg::BSR_LEAD : bsr_pkg::BSR_SHIFT; // RULE_20
            end
            `BSR_SEL_WORD_FOURTH: begin
              next_l.word = word_fourth;
              next_l.state = `BSR_LEAD_EVEN ? bsr_pkg::BSR_LEAD : bsr_pkg::BSR_SHIFT; // RULE_20
            end
            default: begin
              next_l.hist = 21'h000000;
            end
          endcase
        end
      end
      bsr_pkg::BSR_CONV: begin
        next_l.data_bit = 1'h0;
        // Edges after the acknowledge clocks can only come once the host saw the falling edge
        if (l.cnt != `BSR_ACK_CLOCKS) begin
          next_l.cnt = l.cnt + 5'h01; // RULE_08
        end else begin
          next_l.data_bit = c.result[15]; // RULE_12
          next_l.word = {c.result[14:0], 1'h0}; // RULE_10
          next_l.cnt = 5'h01;
          next_l.state = bsr_pkg::BSR_SHIFT;
        end
      end
      bsr_pkg::BSR_LEAD: begin
        next_l.data_bit = 1'h0;
        next_l.state = bsr_pkg::BSR_SHIFT;
      end
      bsr_pkg::BSR_SHIFT: begin
        // A stopped clock simply leaves cnt and word where they are
        if (l.cnt == `BSR_WORD_LAST) begin // RULE_11
          next_l.data_bit = 1'h0; // RULE_10
          next_l.state = bsr_pkg::BSR_IDLE;
          // History kept: a reset pattern may straddle the end of a readout
        end else begin
          next_l.data_bit = l.word[15]; // RULE_02
          next_l.word = {l.word[14:0], 1'h0}; // RULE_24
          next_l.cnt = l.cnt + 5'h01;
        end
      end
      default: begin
        next_l.state = bsr_pkg::BSR_IDLE;
      end
    endcase
    // Pattern beats any state; data line may have moved meanwhile
    if (link_hist_next == `BSR_RESET_PATTERN) begin // RULE_13
      next_l.state = bsr_pkg::BSR_IDLE;
      next_l.data_bit = 1'h0; // RULE_14
      next_l.hist = 21'h000000;
      next_l.cnt = 5'h00;
      next_l.abt_tgl = ~l.abt_tgl;
    end
  end

  always_ff @(posedge sclk_in or negedge rst_l) begin
    if (!rst_l) begin
      l <= '0;
    end else if (ce_l) begin
      l <= next_l;
    end
  end

  assign dout_out = c.dout;
  assign bridge_power_out = c.bridge_on;
  assign sense_temp_out = c.sense_temp;

  sequence seq_conv_start;
    ce_in && core_start;
  endsequence

  sequence seq_ack_high;
    c.busy && c.dout;
  endsequence

  AST_ACK_RISE: assert property (@(posedge core_clk_in) disable iff (!rst_c) // RULE_07
    (seq_conv_start and !core_abort) |=> seq_ack_high)
    else $error("conversion start not acknowledged high");

  AST_STATUS_HIGH: assert property (@(posedge core_clk_in) disable iff (!rst_c) // RULE_16
    c.busy |-> c.dout)
    else $error("data line low during conversion");

  AST_BRIDGE_BRIEF: assert property (@(posedge core_clk_in) disable iff (!rst_c) // RULE_21
    c.bridge_on |-> c.busy && c.tick_cnt < 11'(`BSR_BRIDGE_TICKS))
    else $error("bridge powered outside its window");

  AST_EOC_RESULT: assert property (@(posedge core_clk_in) disable iff (!rst_c) // RULE_09
    ce_in && c.busy && core_tick && c.tick_cnt == 11'(`BSR_CONV_TICKS - 1) && !core_start && !core_abort
    |=> !c.busy && c.result == $past(c.ones) ##1 !c.dout || c.dat_s2)
    else $error("end of conversion not signalled");

  AST_CALIB_STABLE: assert property (@(posedge core_clk_in) disable iff (!rst_c) // RULE_18
    c.calib_loaded |=> $stable(c.calib))
    else $error("calibration data changed after load");

  AST_RESET_PATTERN: assert property (@(posedge sclk_in) disable iff (!rst_l) // RULE_13
    ce_l && link_hist_next == `BSR_RESET_PATTERN |=> l.state == bsr_pkg::BSR_IDLE && !l.data_bit && l.cnt == 5'h00)
    else $error("reset pattern did not resynchronise");

  AST_FRAME_CONV: assert property (@(posedge sclk_in) disable iff (!rst_l) // RULE_05
    ce_l && l.state == bsr_pkg::BSR_IDLE && link_hist_next[9:0] == {`BSR_START_BITS, `BSR_SEL_PRESSURE, `BSR_STOP_BITS}
    && link_hist_next != `BSR_RESET_PATTERN |=> l.state == bsr_pkg::BSR_CONV && $changed(l.req_tgl) && !l.kind_temp)
    else $error("pressure frame not decoded");

  AST_SHIFT_END: assert property (@(posedge sclk_in) disable iff (!rst_l) // RULE_10
    ce_l && l.state == bsr_pkg::BSR_SHIFT && l.cnt == `BSR_WORD_LAST && link_hist_next != `BSR_RESET_PATTERN
    |=> l.state == bsr_pkg::BSR_IDLE && !l.data_bit)
    else $error("readout did not close after the last clock");

  AST_MSB_FIRST: assert property (@(posedge sclk_in) disable iff (!rst_l) // RULE_24
    ce_l && l.state == bsr_pkg::BSR_SHIFT && l.cnt < `BSR_WORD_LAST && link_hist_next != `BSR_RESET_PATTERN
    |=> l.data_bit == $past(link_msb) && l.cnt == $past(l.cnt) + 5'h01)
    else $error("readout bit order wrong");

endmodule : bsr_readout

`default_nettype wire

// >>> verification/bsr_host_model.sv
// Host controller model: drives the shift clock, the command bits and the conversion clock.
// Assumes the device launches data on rising shift clock edges, seen after a core-clock lag.
`timescale 1ns/10ps
`default_nettype none
`include "bsr_map.svh"

module bsr_host_model (
  input wire logic dout_in,
  input wire logic conv_run_in,
  output logic sclk_out,
  output logic din_out,
  output logic conv_clk_out
);
  // Shift clock stands low outside transfers
  initial begin
    sclk_out = 1'b0;
    din_out = 1'b0;
    conv_clk_out = 1'b0;
  end

  // Faster than nominal to keep the run short; held low while stopped in standby
  always #300 conv_clk_out = conv_run_in ? ~conv_clk_out : 1'b0;

  // Command bit changes with the falling edge that ended the previous clock
  task automatic pulse(input logic b);
    din_out = b;
    #40 sclk_out = 1'b1;
    #40 sclk_out = 1'b0;
  endtask : pulse

  task automatic frame(input logic [3:0] sel);
    logic [9:0] f;
    f = {`BSR_START_BITS, sel, `BSR_STOP_BITS};
    for (int i = 9; i >= 0; i--) begin
      pulse(f[i]);
    end
    // Last stop bit leaves the line low
  endtask : frame

  // Data line is not looked at during the pattern
  task automatic resync();
    logic [20:0] p;
    p = `BSR_RESET_PATTERN;
    for (int i = 20; i >= 0; i--) begin
      pulse(p[i]);
    end
    // Pattern ends in zeros, so the line is left low
  endtask : resync

  // Pause after each clock covers the core-side lag of the data line
  task automatic sample(input int unsigned hold_ns, output logic b);
    pulse(1'b0);
    #(hold_ns);
    b = dout_in;
  endtask : sample
endmodule : bsr_host_model
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench of the sensor serial readout with a host model on the link.
// Assumes bsr_map.svh on the include path and a static calibration bank.
`timescale 1ns/10ps
`default_nettype none
`include "bsr_map.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end

module testbench;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic ce_in = 1'b1;
  logic mod_bit_in = 1'b0;
  logic conv_run = 1'b1;
  bsr_pkg::bsr_calib_t calib_in;
  wire sclk;
  wire din;
  wire conv_clk;
  wire dout_out;
  wire bridge_power_out;
  wire sense_temp_out;
  int failures = 0;
  int checks_done = 0;

  assign calib_in = {15'h5A3C, 1'h1, 10'h2B7, 6'h15, 10'h1C9, 6'h2E, 10'h3A5, 6'h0B};

  bsr_readout u_bsr_readout (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
    .sclk_in(sclk), .din_in(din), .conv_clk_in(conv_clk), .mod_bit_in(mod_bit_in),
    .calib_in(calib_in), .dout_out(dout_out), .bridge_power_out(bridge_power_out),
    .sense_temp_out(sense_temp_out));

  bsr_host_model u_bsr_host_model (.dout_in(dout_out), .conv_run_in(conv_run), .sclk_out(sclk), .din_out(din),
    .conv_clk_out(conv_clk));

  always #50 core_clk_in = ~core_clk_in;

  function automatic logic [15:0] exp_word(input int k);
    case (k)
      0: return {calib_in.coef_first, calib_in.coef_fifth_upper_part};
      1: return {calib_in.coef_fifth_lower_part, calib_in.coef_sixth};
      2: return {calib_in.coef_fourth, calib_in.coef_second_upper_part};
      default: return {calib_in.coef_third, calib_in.coef_second_lower_part};
    endcase
  endfunction : exp_word

  task automatic finish_test();
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic wait_dout(input logic v, input int unsigned lim);
    int unsigned n;
    n = 0;
    while (dout_out !== v) begin
      @(negedge core_clk_in);
      n++;
      if (n > lim) begin
        failures++;
        $display("mismatch data line wait expected %h seen %h", v, dout_out);
        finish_test();
      end
    end
  endtask : wait_dout

  // One long pause in mid-word checks that the position is kept
  task automatic read_word(input logic lead, output logic [15:0] w);
    logic b;
    if (lead) begin
      u_bsr_host_model.sample(400, b);
      `CHK("lead bit", 1'b0, b)
    end
    for (int i = 15; i >= 0; i--) begin
      u_bsr_host_model.sample((i == 7) ? 3000 : 400, b);
      w[i] = b;
    end
    u_bsr_host_model.sample(400, b);
    `CHK("closing bit", 1'b0, b)
  endtask : read_word

  // Each frame follows the previous word's readout directly, with no reset pattern between
  task automatic t_calib();
    logic [3:0] sel [4];
    logic [15:0] w;
    sel = '{`BSR_SEL_WORD_FIRST, `BSR_SEL_WORD_SECOND, `BSR_SEL_WORD_THIRD, `BSR_SEL_WORD_FOURTH};
    for (int k = 0; k < 4; k++) begin
      u_bsr_host_model.frame(sel[k]);
      read_word(k[0] ? `BSR_LEAD_EVEN : `BSR_LEAD_ODD, w);
      `CHK("calibration word", exp_word(k), w)
    end
  endtask : t_calib

  task automatic t_refuse();
    u_bsr_host_model.frame(4'h0);
    repeat (10) @(negedge core_clk_in);
    `CHK("unknown select", 1'b0, dout_out)
  endtask : t_refuse

  task automatic t_conv(input logic temp, input int unsigned n);
    logic [15:0] w;
    logic b;
    u_bsr_host_model.resync();
    u_bsr_host_model.frame(temp ? `BSR_SEL_TEMPERATURE : `BSR_SEL_PRESSURE);
    wait_dout(1'b1, 10);
    `CHK("acknowledge", 1'b1, dout_out)
    repeat (2) begin
      u_bsr_host_model.sample(400, b);
      `CHK("status during conversion", 1'b1, b)
    end
    `CHK("temperature select", temp, sense_temp_out)
    `CHK("bridge powered", 1'b1, bridge_power_out)
    repeat (5) @(posedge core_clk_in);
    mod_bit_in <= 1'b1;
    repeat (n) @(posedge core_clk_in);
    mod_bit_in <= 1'b0;
    wait_dout(1'b0, 12000);
    `CHK("bridge off at end", 1'b0, bridge_power_out)
    read_word(1'b0, w);
    `CHK("conversion result", n[15:0], w)
  endtask : t_conv

  task automatic t_abort();
    logic b;
    u_bsr_host_model.frame(`BSR_SEL_PRESSURE);
    wait_dout(1'b1, 10);
    u_bsr_host_model.sample(400, b);
    u_bsr_host_model.sample(400, b);
    u_bsr_host_model.resync();
    wait_dout(1'b0, 20);
    repeat (2000) @(negedge core_clk_in);
    `CHK("aborted conversion", 1'b0, dout_out)
  endtask : t_abort

  initial begin
    repeat (3) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    repeat (3) u_bsr_host_model.pulse(1'b0);
    t_refuse();
    @(posedge core_clk_in);
    conv_run <= 1'b0;
    t_calib();
    @(posedge core_clk_in);
    conv_run <= 1'b1;
    t_conv(1'b0, 37);
    t_conv(1'b1, 250);
    t_abort();
    t_conv(1'b0, 1);
    finish_test();
  end
endmodule : testbench
`undef CHK
`default_nettype wire
